// ===== rsic_regs.vh
/*
  Register offsets, field positions and reset values of the receive
  serializer and interrupt configuration block.
  Assumes it is included by bare name from the design files that need it.
*/
`ifndef RSIC_REGS_VH
`define RSIC_REGS_VH

// Register offsets on the device register port
`define RSIC_OFF_PIN_CFG    6'h05
`define RSIC_OFF_SER_CTL    6'h06
`define RSIC_OFF_RX_IEN     6'h07
`define RSIC_OFF_RX_STAT    6'h08
`define RSIC_OFF_RX_DATA_A  6'h09
`define RSIC_OFF_RX_DATA_B  6'h0B

// Reset values
`define RSIC_RST_PIN_CFG    8'h01
`define RSIC_RST_SER_CTL    8'h03
`define RSIC_RST_RX_IEN     8'h00

// Writable field masks; reserved bits are stored as zero
`define RSIC_MASK_PIN_CFG   8'h03
`define RSIC_MASK_SER_CTL   8'h0F

// Field positions
`define RSIC_PIN_STYLE_HI   1
`define RSIC_PIN_STYLE_LO   0
`define RSIC_BYTE_MODE_BIT  3
`define RSIC_EOF_LEN_HI     2
`define RSIC_EOF_LEN_LO     0

// Enable and status bit positions inside one channel nibble
`define RSIC_BIT_UNDER      3
`define RSIC_BIT_VALID      3
`define RSIC_BIT_OVER       2
`define RSIC_BIT_FLOW       2
`define RSIC_BIT_EOF        1
`define RSIC_BIT_FULL       0

// Interrupt pin drive styles
`define RSIC_STYLE_OPEN_SRC 2'b11
`define RSIC_STYLE_OPEN_DRN 2'b10
`define RSIC_STYLE_CMOS     2'b01
`define RSIC_STYLE_CMOS_INV 2'b00

`endif

// ===== rsic_chan.v
/*
  One receive channel: collects correlated bits into a byte, detects the
  end-of-frame gap and owns the receive data holding register.
  Assumes bit_tick, bit_valid and bit_data come from correlator logic on
  the same clock, one bit_tick pulse per bit time.
*/
`default_nettype none
`include "rsic_regs.vh"

module rsic_chan (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       rx_mode,
  input  wire       byte_mode,
  input  wire [2:0] eof_len,
  input  wire       bit_tick,
  input  wire       bit_valid,
  input  wire       bit_data,
  input  wire       data_rd,
  output reg  [7:0] data,
  output reg        data_full,
  output reg        data_valid,
  output reg        evt_full,
  output reg        evt_ovf,
  output reg        evt_udf,
  output reg        evt_eof
);

  reg [7:0] shift;
  reg [2:0] bit_cnt;
  reg [2:0] gap_cnt;
  reg       armed;

  // Collection, gap counting and holding register; events are one-cycle pulses
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift      <= 8'h00;
      bit_cnt    <= 3'h0;
      gap_cnt    <= 3'h0;
      armed      <= 1'b0;
      data       <= 8'h00;
      data_full  <= 1'b0;
      data_valid <= 1'b0;
      evt_full   <= 1'b0;
      evt_ovf    <= 1'b0;
      evt_udf    <= 1'b0;
      evt_eof    <= 1'b0;
    end else if (ce) begin
      evt_full <= 1'b0;
      evt_ovf  <= 1'b0;
      evt_udf  <= 1'b0;
      evt_eof  <= 1'b0;
      // A read empties the register; reading it empty is an underflow
      if (data_rd) begin
        evt_udf   <= ~data_full;
        data_full <= 1'b0;
      end
      if (!rx_mode) begin
        // Leaving receive mode disarms detection and drops a partial byte
        armed   <= 1'b0;
        bit_cnt <= 3'h0;
        gap_cnt <= 3'h0;
      end else if (bit_tick) begin
        if (bit_valid) begin
          // A new byte starts from zero, so a partial flush carries no bits
          // left over from the previous frame
          shift   <= (bit_cnt == 3'h0) ? {7'h00, bit_data} : {shift[6:0], bit_data};
          armed   <= 1'b1;
          gap_cnt <= 3'h0;
          bit_cnt <= bit_cnt + 3'h1;
          // Whole byte moves to the holding register in byte mode only
          if ((bit_cnt == 3'h7) && byte_mode) begin
            data       <= {shift[6:0], bit_data};
            data_valid <= 1'b1;
            data_full  <= 1'b1;
            evt_full   <= 1'b1;
            evt_ovf    <= data_full & ~data_rd;
          end
        end else if (armed) begin
          // Invalid bit count exceeding the gap length ends the frame
          if (gap_cnt == eof_len) begin
            evt_eof <= 1'b1;
            armed   <= 1'b0;
            bit_cnt <= 3'h0;
            gap_cnt <= 3'h0;
            // Partial byte is flushed in byte mode; nothing is moved if no bit is pending
            if ((bit_cnt != 3'h0) && byte_mode) begin
              data       <= shift;
              data_valid <= 1'b0;
              data_full  <= 1'b1;
              evt_full   <= 1'b1;
              evt_ovf    <= data_full & ~data_rd;
            end
          end else begin
            gap_cnt <= gap_cnt + 3'h1;
          end
        end
      end
    end
  end

endmodule // rsic_chan
`default_nettype wire

// ===== rsic_irq_pad.v
/*
  Interrupt pin driver: turns the internal request level into pin value
  and output enable in one of four drive styles.
  Assumes the pad or bench resolves the wire from out and oe.
*/
`default_nettype none
`include "rsic_regs.vh"

module rsic_irq_pad (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire [1:0] style,
  input  wire       active,
  output reg        pin_out,
  output reg        pin_oe
);

  reg next_out;
  reg next_oe;

  // Style decode; floating styles release the pin when idle
  always @* begin
    next_out = 1'b0;
    next_oe  = 1'b1;
    case (style)
      `RSIC_STYLE_OPEN_SRC: begin
        next_out = 1'b1;
        next_oe  = active;
      end
      `RSIC_STYLE_OPEN_DRN: begin
        next_out = 1'b0;
        next_oe  = active;
      end
      `RSIC_STYLE_CMOS: begin
        next_out = active;
        next_oe  = 1'b1;
      end
      default: begin
        next_out = ~active;
        next_oe  = 1'b1;
      end
    endcase
  end

  // Registered so the pin never glitches on decode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b1;
    end else if (ce) begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

endmodule // rsic_irq_pad
`default_nettype wire

// ===== rsic_top.v
/*
  Receive serializer controls and interrupt logic: pin style, byte or
  bit-serial transfer, end-of-frame gap, per-channel event enables,
  receive status and data registers.
  Assumes a register port driven from the host interface logic on ref_clk,
  correlator bit strobes on the same clock, and rx_mode from the radio mode
  register elsewhere in the device.
*/
// What this block does
// - Styles 11/10 drive asserted level, float idle
// - Styles 01/00 drive both levels, normal/inverted
// - Pin style field is config bits 1:0
// - Serializer bit 3 picks byte or bit-serial
// - Three-bit gap length sets end-of-frame gap
// - Gap counting armed after first valid bit
// - End of frame moves collected data out in byte mode
// - Zero length ends at first invalid bit
// - Enable bits 7:4 gate channel B events
// - Enable bits 3:0 gate channel A events
// - Reading empty data register flags underflow
// - Loading unread data register flags overflow
// - Full flag on every data transfer
// - End-of-frame interrupt when gap exceeded
// - Status read clears pending end-of-frame
// - Status flags set regardless of enables
// - Status at 0x08, event flags cleared when read
// - Status reads zero outside receive mode
`default_nettype none
`include "rsic_regs.vh"

module rsic_top (
  input  wire       ref_clk,
  input  wire       arst_n,
  input  wire       ce,
  input  wire [5:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       rx_mode,
  input  wire       a_bit_tick,
  input  wire       a_bit_valid,
  input  wire       a_bit_data,
  input  wire       b_bit_tick,
  input  wire       b_bit_valid,
  input  wire       b_bit_data,
  output reg        serial_bit_pin_out,
  output reg        serial_bit_pin_oe,
  output reg        serial_bit_valid_pin_out,
  output reg        serial_bit_valid_pin_oe,
  output wire       irq_pin_out,
  output wire       irq_pin_oe
);

  // Sticky flag update: a new event wins over a clear in the same cycle,
  // and everything is held at zero outside receive mode
  function rsic_sticky;
    input flag;
    input evt;
    input clr;
    input rx;
    begin
      rsic_sticky = rx & ((flag & ~clr) | evt);
    end
  endfunction

  // Address match with a strobe; used for every write and read-strobe decode, not the readback mux
  // Only the six offset bits are compared; there is no bank select
  function rsic_hit;
    input [5:0] addr;
    input [5:0] off;
    input       strobe;
    begin
      rsic_hit = strobe & (addr == off);
    end
  endfunction

  reg        rst_meta;
  reg        rst_n;

  reg  [7:0] irq_pin_config;
  reg  [7:0] serializer_control;
  reg  [7:0] rx_event_irq_enable;

  reg  [1:0] flag_udf;
  reg  [1:0] flag_ovf;
  reg  [1:0] flag_eof;
  reg  [1:0] flag_full;

  wire [1:0] pin_style;
  wire       byte_mode_select;
  wire [2:0] eof_len;
  wire       stat_rd;
  wire       data_a_rd;
  wire       data_b_rd;
  wire [7:0] rx_status;
  wire [3:0] pend_a;
  wire [3:0] pend_b;
  wire       irq_active;

  wire [7:0] data_a;
  wire       full_a;
  wire       valid_a;
  wire       evt_full_a;
  wire       evt_ovf_a;
  wire       evt_udf_a;
  wire       evt_eof_a;
  wire [7:0] data_b;
  wire       full_b;
  wire       valid_b;
  wire       evt_full_b;
  wire       evt_ovf_b;
  wire       evt_udf_b;
  wire       evt_eof_b;

  // Reset release through two flops; assertion stays asynchronous.
  // Deliberately not gated by ce, so a frozen block still comes out of
  // reset cleanly once the enable returns.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Control fields
  // A change takes effect on the cycle after the write; a frame in progress
  // sees a new gap length at its next bit time.
  assign pin_style        = irq_pin_config[`RSIC_PIN_STYLE_HI:`RSIC_PIN_STYLE_LO];
  assign byte_mode_select = serializer_control[`RSIC_BYTE_MODE_BIT];
  assign eof_len          = serializer_control[`RSIC_EOF_LEN_HI:`RSIC_EOF_LEN_LO];

  // Read strobes with side effects; frozen clock enable means no access.
  // The host must keep reg_rd to a single-cycle pulse: a strobe held on a
  // data offset would empty the register and then flag underflow.
  assign stat_rd   = rsic_hit(reg_addr, `RSIC_OFF_RX_STAT, reg_rd & ce);
  assign data_a_rd = rsic_hit(reg_addr, `RSIC_OFF_RX_DATA_A, reg_rd & ce);
  assign data_b_rd = rsic_hit(reg_addr, `RSIC_OFF_RX_DATA_B, reg_rd & ce);

  // Control register writes; reserved bits are not stored, which
  // tolerates a host that ignores the write-zero convention
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin_config      <= `RSIC_RST_PIN_CFG;
      serializer_control  <= `RSIC_RST_SER_CTL;
      rx_event_irq_enable <= `RSIC_RST_RX_IEN;
    end else if (ce) begin
      if (rsic_hit(reg_addr, `RSIC_OFF_PIN_CFG, reg_wr)) begin
        irq_pin_config <= reg_wdata & `RSIC_MASK_PIN_CFG;
      end
      if (rsic_hit(reg_addr, `RSIC_OFF_SER_CTL, reg_wr)) begin
        serializer_control <= reg_wdata & `RSIC_MASK_SER_CTL;
      end
      if (rsic_hit(reg_addr, `RSIC_OFF_RX_IEN, reg_wr)) begin
        rx_event_irq_enable <= reg_wdata;
      end
    end
  end

  // Channel A receiver and holding register
  // Only channel A feeds the serial pins in bit-serial mode
  rsic_chan u_chan_a (
    .clk        (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .rx_mode    (rx_mode),
    .byte_mode  (byte_mode_select),
    .eof_len    (eof_len),
    .bit_tick   (a_bit_tick),
    .bit_valid  (a_bit_valid),
    .bit_data   (a_bit_data),
    .data_rd    (data_a_rd),
    .data       (data_a),
    .data_full  (full_a),
    .data_valid (valid_a),
    .evt_full   (evt_full_a),
    .evt_ovf    (evt_ovf_a),
    .evt_udf    (evt_udf_a),
    .evt_eof    (evt_eof_a)
  );

  // Channel B receiver and holding register
  // Channel B shares the gap length and transfer mode with channel A
  rsic_chan u_chan_b (
    .clk        (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .rx_mode    (rx_mode),
    .byte_mode  (byte_mode_select),
    .eof_len    (eof_len),
    .bit_tick   (b_bit_tick),
    .bit_valid  (b_bit_valid),
    .bit_data   (b_bit_data),
    .data_rd    (data_b_rd),
    .data       (data_b),
    .data_full  (full_b),
    .data_valid (valid_b),
    .evt_full   (evt_full_b),
    .evt_ovf    (evt_ovf_b),
    .evt_udf    (evt_udf_b),
    .evt_eof    (evt_eof_b)
  );

  // Sticky event flags: set regardless of enables, cleared by status read.
  // Index 0 is channel A, index 1 channel B.
  // One status read clears both channels at once; an event in the same
  // cycle as that read survives it, so nothing is lost.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_udf  <= 2'h0;
      flag_ovf  <= 2'h0;
      flag_eof  <= 2'h0;
      flag_full <= 2'h0;
    end else if (ce) begin
      flag_udf[0]  <= rsic_sticky(flag_udf[0], evt_udf_a, stat_rd, rx_mode);
      flag_udf[1]  <= rsic_sticky(flag_udf[1], evt_udf_b, stat_rd, rx_mode);
      flag_ovf[0]  <= rsic_sticky(flag_ovf[0], evt_ovf_a, stat_rd, rx_mode);
      flag_ovf[1]  <= rsic_sticky(flag_ovf[1], evt_ovf_b, stat_rd, rx_mode);
      flag_eof[0]  <= rsic_sticky(flag_eof[0], evt_eof_a, stat_rd, rx_mode);
      flag_eof[1]  <= rsic_sticky(flag_eof[1], evt_eof_b, stat_rd, rx_mode);
      flag_full[0] <= rsic_sticky(flag_full[0], evt_full_a, stat_rd, rx_mode);
      flag_full[1] <= rsic_sticky(flag_full[1], evt_full_b, stat_rd, rx_mode);
    end
  end

  // Status image; the whole byte reads zero outside receive mode.
  // Valid counts only while the data register still holds its byte, so a
  // drained register never reports stale valid data.
  assign rx_status = rx_mode ? {valid_b & full_b, flag_udf[1] | flag_ovf[1],
                                flag_eof[1], flag_full[1],
                                valid_a & full_a, flag_udf[0] | flag_ovf[0],
                                flag_eof[0], flag_full[0]}
                             : 8'h00;

  // Pending events in enable-bit order: under, over, end of frame, full
  // Overflow and underflow have separate enables but share one status bit
  assign pend_a = {flag_udf[0], flag_ovf[0], flag_eof[0], flag_full[0]};
  assign pend_b = {flag_udf[1], flag_ovf[1], flag_eof[1], flag_full[1]};

  // Request level: any pending flag whose enable is set.
  // The pad registers this level, so the pin follows one cycle later, and an
  // enable written while a flag is pending acts without a new event.
  assign irq_active = |(pend_b & rx_event_irq_enable[7:4])
                    | |(pend_a & rx_event_irq_enable[3:0]);

  // Registered read data; unmapped offsets read zero.
  // Read data holds until the next read, so the host may take it late.
  // An empty data register returns its stale byte; underflow reports it.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        `RSIC_OFF_PIN_CFG:   reg_rdata <= irq_pin_config;
        `RSIC_OFF_SER_CTL:   reg_rdata <= serializer_control;
        `RSIC_OFF_RX_IEN:    reg_rdata <= rx_event_irq_enable;
        `RSIC_OFF_RX_STAT:   reg_rdata <= rx_status;
        `RSIC_OFF_RX_DATA_A: reg_rdata <= data_a;
        `RSIC_OFF_RX_DATA_B: reg_rdata <= data_b;
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // Bit-serial mode: channel A bits leave on the serial pins. The pins are
  // driven only in receive mode with the serializer off, so a transmit
  // path elsewhere may own them the rest of the time.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_bit_pin_out       <= 1'b0;
      serial_bit_pin_oe        <= 1'b0;
      serial_bit_valid_pin_out <= 1'b0;
      serial_bit_valid_pin_oe  <= 1'b0;
    end else if (ce) begin
      serial_bit_pin_oe       <= rx_mode & ~byte_mode_select;
      serial_bit_valid_pin_oe <= rx_mode & ~byte_mode_select;
      if (a_bit_tick) begin
        serial_bit_pin_out <= a_bit_data;
      end
      serial_bit_valid_pin_out <= rx_mode & ~byte_mode_select & a_bit_tick & a_bit_valid;
    end
  end

  // Interrupt pin in the selected drive style
  // A style change applies one cycle after the write, without a glitch
  rsic_irq_pad u_irq_pad (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .style   (pin_style),
    .active  (irq_active),
    .pin_out (irq_pin_out),
    .pin_oe  (irq_pin_oe)
  );

endmodule // rsic_top
`default_nettype wire

// ===== rsic_top_chk.sv
/* Checker for rsic_top: pin style, config readback, serial pin enable,
   receive status and interrupt hold relations.
   Assumes one ref_clk domain and attachment by the bind at the foot. */
`default_nettype none
module rsic_top_chk (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       ce,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_mode,
  input wire logic       serial_bit_pin_oe,
  input wire logic       irq_pin_out,
  input wire logic       irq_pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] sty;
  logic [3:0] ser;
  logic       irq_on;
  // Shadows of the config fields; reserved bits are never kept
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sty <= 2'h1;
      ser <= 4'h3;
    end else if (ce && reg_wr && reg_addr == 6'h05) begin
      sty <= reg_wdata[1:0];
    end else if (ce && reg_wr && reg_addr == 6'h06) begin
      ser <= reg_wdata[3:0];
    end
  end
  // Asserted level equals the low style bit in all four styles
  assign irq_on = irq_pin_oe && (irq_pin_out == sty[0]);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_quiet;
    ce && rx_mode && !reg_wr && !(reg_rd && reg_addr == 6'h08);
  endsequence
  sequence s_rx_idle;
    !rx_mode [*3];
  endsequence
  property p_open_src;
    sty == 2'b11 && $past(sty) == 2'b11 && irq_pin_oe |-> irq_pin_out;
  endproperty
  property p_open_drn;
    sty == 2'b10 && $past(sty) == 2'b10 && irq_pin_oe |-> !irq_pin_out;
  endproperty
  property p_push_pull;
    !sty[1] && !$past(sty[1]) |-> irq_pin_oe;
  endproperty
  property p_pin_rd;
    ce && reg_rd && reg_addr == 6'h05 |=> reg_rdata == {6'h00, $past(sty)};
  endproperty
  property p_ser_rd;
    ce && reg_rd && reg_addr == 6'h06 |=> reg_rdata == {4'h0, $past(ser)};
  endproperty
  property p_ser_on;
    (rx_mode && !ser[3]) [*3] |-> serial_bit_pin_oe;
  endproperty
  property p_ser_off;
    (!rx_mode || ser[3]) [*3] |-> !serial_bit_pin_oe;
  endproperty
  property p_stat_off;
    s_rx_idle ##0 (ce && reg_rd && reg_addr == 6'h08) |=> reg_rdata == 8'h00;
  endproperty
  property p_irq_hold;
    s_quiet ##1 (s_quiet ##0 irq_on) |=> irq_on;
  endproperty
  a_open_src: assert property (p_open_src) else $error("open source pin drove low");
  a_open_drn: assert property (p_open_drn) else $error("open drain pin drove high");
  a_push_pull: assert property (p_push_pull) else $error("push pull pin floated");
  a_pin_rd: assert property (p_pin_rd) else $error("pin config readback wrong");
  a_ser_rd: assert property (p_ser_rd) else $error("serializer readback wrong");
  a_ser_on: assert property (p_ser_on) else $error("serial pins not driven");
  a_ser_off: assert property (p_ser_off) else $error("serial pins driven");
  a_stat_off: assert property (p_stat_off) else $error("status nonzero off rx");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
endmodule // rsic_top_chk
bind rsic_top rsic_top_chk u_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_mode(rx_mode),
  .serial_bit_pin_oe(serial_bit_pin_oe), .irq_pin_out(irq_pin_out),
  .irq_pin_oe(irq_pin_oe)
);
`default_nettype wire

// ===== rsic_host_model.sv
/* Host model: register strobe cycles and the interrupt wire level.
   Assumes the bench calls its tasks and that reg_rdata is registered. */
`default_nettype none
module rsic_host_model (
  input  wire logic       ref_clk,
  output var  logic [5:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       irq_pin_out,
  input  wire logic       irq_pin_oe,
  output wire logic       irq_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // No pull on the pin: a floated wire shows the inverse of the last drive
  always @(posedge ref_clk) begin
    if (irq_pin_oe) begin
      last <= irq_pin_out;
    end
  end
  assign irq_wire = irq_pin_oe ? irq_pin_out : ~last;
  // One-cycle write; reserved upper bits are always sent as zero
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= (a == 6'h05) ? {6'h00, d[1:0]} : (a == 6'h06) ? {4'h0, d[3:0]} : d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read; data is taken once the taking edge has settled
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
endmodule // rsic_host_model
`default_nettype wire

// ===== rsic_top_tb_top.sv
/* Self-checking bench for rsic_top: registers, byte collection, flow
   events, end-of-frame gap, interrupt styles and bit-serial pins.
   Assumes rsic_host_model and the bound checker are compiled first. */
`default_nettype none
module rsic_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       rx_mode = 1'b0;
  logic [1:0] tk = 2'b00;
  logic [1:0] vl = 2'b00;
  logic [1:0] dt = 2'b00;
  logic [7:0] rd;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         vpulse = 0;
  wire logic [5:0] reg_addr;
  wire logic [7:0] reg_wdata, reg_rdata;
  wire logic       reg_wr, reg_rd, irq_wire, irq_pin_out, irq_pin_oe;
  wire logic       sb_out, sb_oe, sv_out, sv_oe;
  rsic_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_mode(rx_mode), .a_bit_tick(tk[0]), .a_bit_valid(vl[0]), .a_bit_data(dt[0]),
    .b_bit_tick(tk[1]), .b_bit_valid(vl[1]), .b_bit_data(dt[1]),
    .serial_bit_pin_out(sb_out), .serial_bit_pin_oe(sb_oe),
    .serial_bit_valid_pin_out(sv_out), .serial_bit_valid_pin_oe(sv_oe),
    .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));
  rsic_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .irq_wire(irq_wire));
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // Pulse counter on the bit-valid pin, and a hang limit far above the run
  always @(posedge ref_clk) begin
    vpulse <= vpulse + int'(sv_out === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp, input string nm);
    host.rd(a, rd);
    chk(nm, rd, exp);
  endtask
  // Waits end at a falling edge so registered outputs have settled
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic tick(input int ch, input logic v, input logic d);
    @(posedge ref_clk);
    tk[ch] <= 1'b1;
    vl[ch] <= v;
    dt[ch] <= d;
    @(posedge ref_clk);
    tk <= 2'b00;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic send_byte(input int ch, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) tick(ch, 1'b1, b[i]);
  endtask
  // Empties both data registers and drops stale flags by leaving receive
  task automatic clean();
    host.rd(6'h09, rd);
    host.rd(6'h0B, rd);
    @(posedge ref_clk);
    rx_mode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rx_mode <= 1'b1;
    wait_cyc(3);
  endtask
  task automatic t_regs();
    rdc(6'h05, 8'h01, "pin_cfg_rst");
    rdc(6'h06, 8'h03, "ser_ctl_rst");
    rdc(6'h07, 8'h00, "ien_rst");
    host.wr(6'h05, 8'hFE);
    rdc(6'h05, 8'h02, "pin_cfg");
    host.wr(6'h07, 8'hA5);
    rdc(6'h07, 8'hA5, "ien");
    host.wr(6'h07, 8'h00);
    rdc(6'h0A, 8'h00, "unmapped");
  endtask
  task automatic t_byte();
    host.wr(6'h06, 8'h08);
    clean();
    for (int ch = 0; ch < 2; ch++) begin
      send_byte(ch, 8'hA5 ^ 8'(ch));
      rdc(6'h08, 8'h09 << (4 * ch), "stat_full");
      rdc(ch ? 6'h0B : 6'h09, 8'hA5 ^ 8'(ch), "data");
      host.rd(ch ? 6'h0B : 6'h09, rd);
      rdc(6'h08, 8'h04 << (4 * ch), "stat_udf");
      rdc(6'h08, 8'h00, "stat_clr");
    end
  endtask
  task automatic t_ovf();
    clean();
    send_byte(0, 8'h3C);
    send_byte(0, 8'hC3);
    rdc(6'h08, 8'h0D, "stat_ovf");
    rdc(6'h09, 8'hC3, "data_ovf");
    send_byte(1, 8'hFF);
    @(posedge ref_clk);
    rx_mode <= 1'b0;
    wait_cyc(3);
    rdc(6'h08, 8'h00, "stat_off");
  endtask
  task automatic t_eof();
    clean();
    tick(0, 1'b0, 1'b1);
    tick(0, 1'b1, 1'b1);
    tick(0, 1'b1, 1'b0);
    tick(0, 1'b1, 1'b1);
    rdc(6'h08, 8'h00, "stat_arm");
    tick(0, 1'b0, 1'b0);
    rdc(6'h08, 8'h03, "stat_eof0");
    rdc(6'h09, 8'h05, "part_a");
    host.wr(6'h06, 8'h0A);
    clean();
    tick(1, 1'b1, 1'b1);
    tick(1, 1'b0, 1'b0);
    tick(1, 1'b0, 1'b0);
    rdc(6'h08, 8'h00, "stat_gap");
    tick(1, 1'b0, 1'b0);
    rdc(6'h08, 8'h30, "stat_eof2");
    rdc(6'h0B, 8'h01, "part_b");
  endtask
  task automatic t_irq();
    host.wr(6'h06, 8'h08);
    host.wr(6'h07, 8'h01);
    for (int s = 3; s >= 0; s--) begin
      host.wr(6'h05, 8'(s));
      clean();
      send_byte(0, 8'h55);
      wait_cyc(2);
      chk("irq_on", {6'h00, irq_pin_oe, irq_wire}, {7'h01, s[0]});
      host.rd(6'h08, rd);
      wait_cyc(2);
      chk("irq_idle", {6'h00, irq_pin_oe, irq_pin_oe & irq_pin_out},
        {6'h00, ~s[1], ~s[1] & ~s[0]});
    end
    host.wr(6'h07, 8'h10);
    clean();
    send_byte(0, 8'h55);
    wait_cyc(2);
    chk("irq_masked", {7'h00, irq_wire}, 8'h01);
    host.wr(6'h07, 8'h01);
    wait_cyc(2);
    chk("irq_unmask", {7'h00, irq_wire}, 8'h00);
    host.wr(6'h05, 8'h01);
  endtask
  task automatic t_bit();
    host.wr(6'h06, 8'h03);
    clean();
    // Earlier scenarios never run bit-serial receive, so the count starts at zero
    tick(0, 1'b1, 1'b1);
    tick(0, 1'b1, 1'b1);
    wait_cyc(1);
    chk("bit_oe", {7'h00, sb_oe}, 8'h01);
    chk("bit_valid_oe", {7'h00, sv_oe}, 8'h01);
    chk("bit_pin", {7'h00, sb_out}, 8'h01);
    chk("valid_pulses", vpulse[7:0], 8'h02);
    rdc(6'h08, 8'h00, "stat_bit");
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    wait_cyc(3);
    t_regs();
    t_byte();
    t_ovf();
    t_eof();
    t_irq();
    t_bit();
    end_of_test();
  end
endmodule // rsic_top_tb_top
`default_nettype wire
